// *** hdl/sadc_pkg.sv ***
/*
  Package of the SAR converter control block: bus map, field positions,
  reset values, timing counts and shared types.
  Assumes a 100 MHz system clock and a 32-bit AHB-Lite register bus.
*/
package sadc_pkg;

  // Word length of the approximation and result.
  localparam int SAR_BITS = 14;

  // Clock period in ns.
  localparam int CLK_NS = 10;

  // Conversion time, acquisition time and nap wake-up, in ns.
  localparam int CONV_NS = 260;
  localparam int ACQ_NS = 100;
  localparam int NAP_WAKE_NS = 250;
  // Sleep wake-up in ms.
  localparam int SLEEP_WAKE_MS = 210;

  // Derived cycle counts; typical figures round up to whole cycles.
  localparam int CONV_CYC = (CONV_NS + CLK_NS - 1) / CLK_NS;
  localparam int STEP_CYC = CONV_CYC / SAR_BITS;
  localparam int ACQ_CYC = (ACQ_NS + CLK_NS - 1) / CLK_NS;
  localparam int NAP_WAKE_CYC = (NAP_WAKE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SLEEP_WAKE_CYC = SLEEP_WAKE_MS * (1000000 / CLK_NS);

  // Register byte offsets.
  localparam logic [7:0] OFS_RESULT = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
  localparam logic [7:0] OFS_CTRL = 8'h10;

  // RESULT fields.
  localparam int RES_RANGE_BIT = 16;
  // STATUS fields.
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_NAP_BIT = 1;
  localparam int ST_SLEEP_BIT = 2;
  localparam int ST_WAKE_BIT = 3;
  localparam int ST_SPAN_LSB = 4;
  // Interrupt bits: done, range exceeded, start ignored.
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_RANGE_BIT = 1;
  localparam int IRQ_IGN_BIT = 2;
  localparam int IRQ_W = 3;
  // CTRL fields: software start strobe.
  localparam int CTRL_START_BIT = 0;

  // Reset values.
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
  localparam logic [SAR_BITS-1:0] RESULT_RST = 14'h0000;

  // Two's complement code of the most negative input, and the MSB trial.
  localparam logic [SAR_BITS-1:0] SAR_MSB = 14'h2000;

  // Input span, coded as attenuation steps of 3 dB.
  typedef enum logic [1:0] {
    SADC_SPAN_0DB = 2'h0,
    SADC_SPAN_M3DB = 2'h1,
    SADC_SPAN_M6DB = 2'h2,
    SADC_SPAN_M9DB = 2'h3
  } sadc_span_e;

  // Latched conversion result.
  typedef struct packed {
    logic range_exceeded;
    logic [SAR_BITS-1:0] data;
  } sadc_result_s;

  // Power controls to the analog section.
  typedef struct packed {
    logic conv_off;
    logic ref_off;
  } sadc_power_s;

endpackage

// *** hdl/sadc_ctrl.sv ***
/*
  Conversion control of a 14-bit SAR converter: start edge detection,
  bit sequencing, output latches, span decode, shutdown and an AHB-Lite
  register slave with interrupt.
  Assumes all pins synchronous to hclk and an analog section that
  returns a comparator decision one cycle after each trial word.
*/
// The AHB-Lite interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/10ps

// Contract
// - Falling start edge begins a conversion.
// - Starts during conversion ignored, never restart.
// - Busy low exactly while converting.
// - Host allows 100ns acquisition between conversions.
// - One bit per step, MSB first.
// - Completed word latched, held until next.
// - Highest output bit carries the MSB.
// - Flag high, MSB low means overrange.
// - Two span pins select four spans.
// - Nap low powers conversion, keeps reference.
// - Sleep low powers everything down.
// - Unconnected shutdown pins read low, shut down.
// - Result is two's complement about negative input.
// - Conversion takes about 260ns.
// - Flag on most negative code or top overrange.
// - Host waits 250ns after nap release.
module sadc_ctrl #(
  parameter int SLEEP_WAKE = sadc_pkg::SLEEP_WAKE_CYC
) (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Host pins.
  input wire logic start_n,
  input wire logic span_sel_0,
  input wire logic span_sel_1,
  input wire logic nap_n,
  input wire logic deep_shutdown_n,
  output logic busy_n,
  output sadc_pkg::sadc_result_s result,
  // Analog section.
  input wire logic cmp_above,
  input wire logic over_top,
  output logic [sadc_pkg::SAR_BITS-1:0] dac_code,
  output logic track,
  output sadc_pkg::sadc_span_e span_level,
  output sadc_pkg::sadc_power_s power,
  // Interrupt.
  output logic irq
);
  import sadc_pkg::*;

  typedef enum logic [3:0] {
    SADC_IDLE = 4'h1,
    SADC_CONV = 4'h2,
    SADC_PAD = 4'h4,
    SADC_LATCH = 4'h8
  } sadc_state_e;

  sadc_state_e state;
  logic start_q;
  logic sw_start;
  logic [4:0] step_cnt;
  logic [4:0] conv_cnt;
  logic [3:0] bit_idx;
  logic [24:0] wake_cnt;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic start_req;
  logic shut;
  logic launch;
  logic dec_now;
  logic pad_done;
  logic [SAR_BITS-1:0] code;
  logic [31:0] rd_word;

  // Converts a 5-bit cycle count into its wrap limit.
  function automatic logic [4:0] cyc5(input int n);
    cyc5 = 5'(n - 1);
  endfunction

  // shutdown asserted
  // A pin pulled low by its internal pull-down means shutdown.
  assign shut = !nap_n || !deep_shutdown_n;

  // falling edge start
  // A falling start pin or a software strobe requests a conversion.
  assign start_req = (start_q && !start_n) || sw_start;

  // gate start request
  // Starts are launched only when idle, awake and not shut down.
  assign launch = start_req && state == SADC_IDLE && !shut &&
                  wake_cnt == 25'h0000000;

  // A bit is decided at the last cycle of each step.
  assign dec_now = state == SADC_CONV && step_cnt == cyc5(STEP_CYC);

  // Padding ends one cycle short of the whole conversion time; the latch cycle completes it.
  assign pad_done = state == SADC_PAD && conv_cnt >= cyc5(CONV_CYC - 1);

  // two's complement code
  // Flipping the MSB turns the offset binary SAR word into two's complement.
  assign code = dac_code ^ SAR_MSB;

  // Edge detector on the start pin; idle level is high.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      start_q <= 1'b1;
    end else begin
      start_q <= start_n;
    end
  end

  // Wake-up timer, reloaded while shut down and counted after release.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_cnt <= 25'h0000000;
    end else if (!deep_shutdown_n) begin
      wake_cnt <= 25'(SLEEP_WAKE);
    end else if (!nap_n) begin
      wake_cnt <= 25'(NAP_WAKE_CYC);
    end else if (wake_cnt != 25'h0000000) begin
      wake_cnt <= wake_cnt - 25'h0000001;
    end
  end

  // Conversion sequencer.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= SADC_IDLE;
      step_cnt <= 5'h00;
      conv_cnt <= 5'h00;
    end else begin
      case (state)
        SADC_IDLE: begin
          if (launch) begin
            state <= SADC_CONV;
            step_cnt <= 5'h00;
            conv_cnt <= 5'h00;
          end
        end
        SADC_CONV: begin
          conv_cnt <= conv_cnt + 5'h01;
          if (dec_now) begin
            step_cnt <= 5'h00;
            if (bit_idx == 4'h0) begin
              state <= SADC_PAD;
            end
          end else begin
            step_cnt <= step_cnt + 5'h01;
          end
        end
        SADC_PAD: begin
          conv_cnt <= conv_cnt + 5'h01;
          if (pad_done) begin
            state <= SADC_LATCH;
          end
        end
        SADC_LATCH: begin
          state <= SADC_IDLE;
        end
        default: begin
          state <= SADC_IDLE;
        end
      endcase
    end
  end

  // Successive approximation register; the trial word drives the DAC.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dac_code <= SAR_MSB;
      bit_idx <= 4'h0;
    end else if (launch) begin
      dac_code <= SAR_MSB;
      bit_idx <= 4'(SAR_BITS - 1);
    end else if (dec_now) begin
      dac_code[bit_idx] <= cmp_above;
      if (bit_idx != 4'h0) begin
        dac_code[bit_idx - 4'h1] <= 1'b1;
        bit_idx <= bit_idx - 4'h1;
      end
    end
  end

  // Output latches, loaded once per conversion, one cycle ahead of busy
  // rising so that a host sampling on that edge sees settled data.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result <= '{range_exceeded: 1'b0, data: RESULT_RST};
    end else if (pad_done) begin
      result.data <= code;
      // overrange reads flag high, MSB low
      result.range_exceeded <= over_top || code == SAR_MSB;
    end
  end

  // Busy and sample-and-hold control follow the sequencer.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_n <= 1'b1;
      track <= 1'b1;
    end else begin
      busy_n <= !(launch || (state != SADC_IDLE &&
                state != SADC_LATCH));
      track <= !(launch || state == SADC_CONV || state == SADC_PAD);
    end
  end

  // Span and power controls to the analog section.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      span_level <= SADC_SPAN_0DB;
      power <= '{conv_off: 1'b1, ref_off: 1'b1};
    end else begin
      case ({span_sel_0, span_sel_1})
        2'b11: span_level <= SADC_SPAN_0DB;
        2'b10: span_level <= SADC_SPAN_M3DB;
        2'b01: span_level <= SADC_SPAN_M6DB;
        default: span_level <= SADC_SPAN_M9DB;
      endcase
      power.conv_off <= shut;
      power.ref_off <= !deep_shutdown_n;
    end
  end

  // Interrupt events and write-one-to-clear requests.
  always_comb begin
    irq_set = '0;
    irq_set[IRQ_DONE_BIT] = state == SADC_LATCH;
    irq_set[IRQ_RANGE_BIT] = state == SADC_LATCH && result.range_exceeded;
    irq_set[IRQ_IGN_BIT] = start_req && !launch;
    irq_clr = '0;
    if (wr_pend && wr_addr == OFS_IRQ_STAT) begin
      irq_clr = hwdata[IRQ_W-1:0];
    end
  end

  // Sticky status: a new event wins over a clear in the same cycle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat <= '0;
      irq <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_set;
      irq <= |(((irq_stat & ~irq_clr) | irq_set) & irq_mask);
    end
  end

  // Read mux over the register map; unmapped offsets read zero.
  always_comb begin
    rd_word = 32'h00000000;
    case (haddr[7:0])
      OFS_RESULT: begin
        rd_word[SAR_BITS-1:0] = result.data;
        rd_word[RES_RANGE_BIT] = result.range_exceeded;
      end
      OFS_STATUS: begin
        rd_word[ST_BUSY_BIT] = !busy_n;
        rd_word[ST_NAP_BIT] = !nap_n;
        rd_word[ST_SLEEP_BIT] = !deep_shutdown_n;
        rd_word[ST_WAKE_BIT] = wake_cnt != 25'h0000000;
        rd_word[ST_SPAN_LSB +: 2] = span_level;
      end
      OFS_IRQ_STAT: rd_word[IRQ_W-1:0] = irq_stat;
      OFS_IRQ_MASK: rd_word[IRQ_W-1:0] = irq_mask;
      default: rd_word = 32'h00000000;
    endcase
  end

  // AHB-Lite slave: zero wait states, always OKAY.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend <= hsel && htrans[1] && hready && hwrite;
      wr_addr <= haddr[7:0];
      if (hsel && htrans[1] && hready && !hwrite) begin
        hrdata <= rd_word;
      end
    end
  end

  // Writable registers: mask and the software start strobe.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_mask <= IRQ_MASK_RST;
      sw_start <= 1'b0;
    end else begin
      sw_start <= 1'b0;
      if (wr_pend && wr_addr == OFS_IRQ_MASK) begin
        irq_mask <= hwdata[IRQ_W-1:0];
      end
      if (wr_pend && wr_addr == OFS_CTRL) begin
        sw_start <= hwdata[CTRL_START_BIT];
      end
    end
  end

endmodule

// *** tb/sadc_ctrl_sva.sv ***
/*
  Checker of the converter control pins, bound into the control module.
  Assumes one clock, hclk, and the asynchronous active-low hresetn.
*/
`timescale 1ns/10ps
module sadc_ctrl_sva #(
  parameter int SLEEP_WAKE = sadc_pkg::SLEEP_WAKE_CYC
) (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Bus answer.
  input wire logic hreadyout,
  input wire logic hresp,
  // Host pins.
  input wire logic start_n,
  input wire logic span_sel_0,
  input wire logic span_sel_1,
  input wire logic nap_n,
  input wire logic deep_shutdown_n,
  input wire logic busy_n,
  input wire sadc_pkg::sadc_result_s result,
  // Analog side.
  input wire logic over_top,
  input wire logic [sadc_pkg::SAR_BITS-1:0] dac_code,
  input wire logic track,
  input wire sadc_pkg::sadc_span_e span_level,
  input wire sadc_pkg::sadc_power_s power
);
  import sadc_pkg::*;
  localparam int WAKE_MIN = SLEEP_WAKE + NAP_WAKE_CYC + 2;
  int awake;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Counts cycles since both shutdown pins went high, so wake is over.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      awake <= 0;
    end else if (!nap_n || !deep_shutdown_n) begin
      awake <= 0;
    end else if (awake < WAKE_MIN) begin
      awake <= awake + 1;
    end
  end

  start_go_a: assert property ($fell(start_n) && busy_n &&
    awake >= WAKE_MIN |=> !busy_n) else $error("start edge was lost");
  busy_len_a: assert property ($fell(busy_n) |->
    (!busy_n)[*8] ##1 (!busy_n)[*8] ##1 (!busy_n)[*8] ##1
    (!busy_n)[*2] ##1 busy_n) else $error("busy length wrong");
  msb_first_a: assert property ($fell(busy_n) |->
    dac_code == SAR_MSB ##1 dac_code[SAR_BITS-3:0] == '0)
    else $error("first trial is not the top bit");
  result_a: assert property ($rose(busy_n) |->
    $stable(result) &&
    result.data == ($past(dac_code, 2) ^ SAR_MSB))
    else $error("result differs from final trial word");
  hold_a: assert property (busy_n && $past(busy_n) |->
    $stable(result)) else $error("result changed while idle");
  range_a: assert property ($rose(busy_n) |->
    result.range_exceeded == (over_top || result.data == SAR_MSB))
    else $error("range flag wrong");
  shut_a: assert property (busy_n && !(nap_n && deep_shutdown_n)
    |=> busy_n) else $error("conversion ran in shutdown");
  power_a: assert property (1'b1 |=> power ==
    {!$past(nap_n) || !$past(deep_shutdown_n), !$past(deep_shutdown_n)})
    else $error("power controls do not follow pins");
  span_a: assert property (1'b1 |=> span_level ==
    {!$past(span_sel_0), !$past(span_sel_1)}) else $error("span wrong");
  bus_ok_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready and okay");
  track_a: assert property (track == busy_n)
    else $error("track does not follow busy");
endmodule

bind sadc_ctrl sadc_ctrl_sva #(.SLEEP_WAKE(SLEEP_WAKE)) u_sva (.hclk,
  .hresetn, .hreadyout, .hresp, .start_n, .span_sel_0, .span_sel_1,
  .nap_n, .deep_shutdown_n, .busy_n, .result, .over_top, .dac_code,
  .track, .span_level, .power);

// *** tb/sadc_host_model.sv ***
/*
  Host that strobes the start pin, plus the comparator of the analog side.
  Assumes go is held high by the bench until busy has been seen low.
*/
`timescale 1ns/10ps
module sadc_host_model (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Host side.
  input wire logic go,
  input wire logic busy_n,
  input wire logic nap_n,
  output logic start_n,
  // Analog side.
  input wire logic [13:0] target,
  input wire logic [13:0] dac_code,
  output logic cmp_above
);
  import sadc_pkg::*;
  int idle_cnt;

  // input sits half a step above target, so ties never occur.
  assign cmp_above = {target, 1'b1} > {dac_code, 1'b0};

  // falling start only after acquisition and nap wake time.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idle_cnt <= 0;
      start_n <= 1'b1;
    end else begin
      idle_cnt <= (!busy_n || !nap_n) ? 0 : idle_cnt + 1;
      start_n <= !(go && (!start_n || idle_cnt >= NAP_WAKE_CYC + ACQ_CYC));
    end
  end
endmodule

// *** tb/sadc_ctrl_bench.sv ***
/*
  Bench of the converter control: bus tasks, host model and scenarios.
  Assumes the package, control module and checker are compiled first.
*/
`timescale 1ns/10ps
`define CHECK(g, e) begin total_checks++; if ((g) !== (e)) begin \
  err_count++; $display("unexpected at %0t: got %h want %h", $time, g, e); \
  end end
module sadc_ctrl_bench;
  import sadc_pkg::*;
  localparam int WAKE = 50;
  localparam logic [13:0] TV [5] = '{14'h0, 14'h3fff, 14'h2000, 14'h1555,
    14'h2aaa};
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, go = 1'b0;
  logic nap_n = 1'b1, deep_shutdown_n = 1'b1, over_top = 1'b0, rng;
  logic span_sel_0 = 1'b1, span_sel_1 = 1'b1;
  logic [1:0] htrans = 2'h0, sp;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, hrdata;
  logic [13:0] target = 14'h0, dac_code;
  logic hreadyout, hresp, busy_n, start_n, cmp_above, irq;
  sadc_result_s result;
  sadc_span_e span_level;
  sadc_power_s power;
  int err_count = 0, total_checks = 0, n;

  // Clock of 10 ns period.
  always #5 hclk = ~hclk;

  sadc_ctrl #(.SLEEP_WAKE(WAKE)) u_dut (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata,
    .hreadyout, .hresp, .start_n, .span_sel_0, .span_sel_1, .nap_n,
    .deep_shutdown_n, .busy_n, .result, .cmp_above, .over_top, .dac_code,
    .track(), .span_level, .power, .irq);
  sadc_host_model u_host (.hclk, .hresetn, .go, .busy_n, .nap_n, .start_n,
    .target, .dac_code, .cmp_above);

  // One single word transfer; read data is taken at the data edge.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHECK(rd, e)
  endtask
  // Launch holds go until busy is seen low; finish waits until it is seen high again.
  task automatic launch(input logic [13:0] t, input logic ot);
    target <= t;
    over_top <= ot;
    go <= 1'b1;
    for (n = 0; busy_n !== 1'b0 && n < 200; n++) @(posedge hclk);
    go <= 1'b0;
  endtask
  task automatic finish();
    for (n = 0; busy_n !== 1'b1 && n < 200; n++) @(posedge hclk);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Watchdog well beyond the expected run of some 5 us.
  initial begin
    #100us;
    err_count++;
    end_of_test();
  end

  // Main sequence of tests.
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    `CHECK(busy_n, 1'b1)
    `CHECK(result, 15'h0)
    rdchk(OFS_IRQ_MASK, 32'h0);
    rdchk(8'h20, 32'h0);
    $display("test reset ended");
    wr(OFS_IRQ_MASK, 32'h1);
    for (int i = 0; i < 5; i++) begin
      rng = (i == 1) || (TV[i] == 14'h0);
      launch(TV[i], i == 1);
      finish();
      `CHECK(n, CONV_CYC)
      `CHECK(result, {rng, TV[i] ^ SAR_MSB})
      `CHECK(irq, 1'b1)
      rdchk(OFS_RESULT, {15'h0, rng, 2'h0, TV[i] ^ SAR_MSB});
      wr(OFS_IRQ_STAT, 32'h7);
      rdchk(OFS_IRQ_STAT, 32'h0);
      `CHECK(irq, 1'b0)
    end
    $display("test conversions ended");
    launch(14'h1234, 1'b0);
    wr(OFS_CTRL, 32'h1);
    finish();
    rdchk(OFS_IRQ_STAT, 32'h5);
    `CHECK(result.data, 14'h1234 ^ SAR_MSB)
    wr(OFS_IRQ_MASK, 32'h0);
    rdchk(OFS_IRQ_MASK, 32'h0);
    `CHECK(irq, 1'b0)
    wr(OFS_IRQ_STAT, 32'h7);
    $display("test refusal ended");
    nap_n <= 1'b0;
    wr(OFS_CTRL, 32'h1);
    rdchk(OFS_IRQ_STAT, 32'h4);
    `CHECK(busy_n, 1'b1)
    `CHECK(power, 2'b10)
    deep_shutdown_n <= 1'b0;
    rdchk(OFS_IRQ_MASK, 32'h0);
    `CHECK(power, 2'b11)
    nap_n <= 1'b1;
    deep_shutdown_n <= 1'b1;
    wr(OFS_IRQ_STAT, 32'h7);
    repeat (WAKE + 5) @(posedge hclk);
    launch(14'h0abc, 1'b0);
    finish();
    `CHECK(result.data, 14'h0abc ^ SAR_MSB)
    $display("test shutdown ended");
    for (int i = 0; i < 4; i++) begin
      {span_sel_0, span_sel_1} <= i[1:0];
      sp = ~i[1:0];
      rdchk(OFS_STATUS, {26'h0, sp, 4'h0});
      `CHECK(span_level, sp)
    end
    $display("test spans ended");
    end_of_test();
  end
endmodule
